// *** pkg/hsb_pkg.sv ***
// package for the halt state bus control block
package hsb_pkg;
    localparam logic [2:0] HSB_STATUS_HALT = 3'h3;
    localparam logic [2:0] HSB_STATUS_IDLE = 3'h7;
    localparam logic [2:0] HSB_STATUS_READ_MEM = 3'h5;
    localparam logic [2:0] HSB_STATUS_READ_IO = 3'h1;
    localparam logic [2:0] HSB_STATUS_FETCH = 3'h4;
    localparam logic [2:0] HSB_STATUS_INTA = 3'h0;
    localparam logic [3:0] HSB_NIBBLE_DMA = 4'h8;
    localparam logic [3:0] HSB_NIBBLE_ZERO = 4'h0;
    localparam logic [1:0] HSB_VECTOR_READS = 2'h2;
    localparam logic HSB_TXDIR_RESET = 1'b1;

    typedef enum logic [1:0] {
        HSB_AD_FLOAT,
        HSB_AD_WRITE_DATA,
        HSB_AD_PREFETCH
    } hsb_ad_mode_t;

    // one bus cycle request from the execution side
    typedef struct packed {
        logic valid;
        logic [2:0] status;
        logic [19:0] addr;
        logic [15:0] data;
        logic dma_or_refresh;
    } hsb_cycle_t;

    // bus pin group driven by the block
    typedef struct packed {
        logic ale;
        logic [2:0] bus_cycle_status;
        logic [15:0] ad_out;
        logic ad_oe;
        logic [7:0] upper_address_byte;
        logic [3:0] upper_address_nibble;
        logic upper_byte_enable;
        logic transceiver_data_enable_n;
        logic transceiver_direction;
        logic chip_select_block;
    } hsb_pins_t;
endpackage : hsb_pkg

// *** rtl/hsb_halt_bus.sv ***
// halt bus state, transceiver control and wait instruction suspension
// Behaviour
// - halt exits temporarily for dma, refresh, hold
// - returns to halt after that operation ends
// - halt status 011, no repeat on return
// - ad lines float, write data or prefetch
// - 8-bit upper byte shows prior or prefetch
// - upper nibble zero, or 8h after dma or refresh
// - nmi or unmasked interrupt ends halt
// - first cycles after halt fetch vector
// - data enable and direction outputs provided
// - direction low only for read-type cycles
// - wait suspends until interrupt or release low
// - stays suspended while release input high
// - release low resumes in place, no jump
// - halt instruction runs one halt cycle
// - chip-selects kept inactive in halt cycle
`timescale 1ns/100ps
module hsb_halt_bus
    import hsb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic halt_exec,
    input wire logic wait_exec,
    input wire logic bus_8bit,
    input wire hsb_ad_mode_t halt_ad_mode,
    input wire logic [15:0] last_write_data,
    input wire logic [19:0] prefetch_addr,
    input wire logic [19:0] prev_addr,
    input wire logic upper_addr_from_prefetch,
    input wire logic dma_req,
    input wire logic refresh_req,
    input wire logic hold_req,
    input wire logic temp_op_done,
    input wire logic nmi,
    input wire logic maskable_interrupt_inputs,
    input wire logic interrupt_mask,
    input wire logic wait_release_n,
    input wire hsb_cycle_t cycle_in,
    output hsb_pins_t pins,
    output logic halted,
    output logic temp_exit,
    output logic exec_suspended,
    output logic vector_fetch,
    output logic resume_next,
    output logic vector_jump
);
    typedef enum logic [2:0] {
        HSB_RUN,
        HSB_HALT_CYCLE,
        HSB_HALTED,
        HSB_TEMP_EXIT,
        HSB_VECTOR,
        HSB_WAITING
    } hsb_state_t;

    hsb_state_t state_reg, state_next;
    hsb_pins_t pins_reg, pins_next;
    logic [1:0] vec_cnt_reg, vec_cnt_next;
    logic sync1_reg, sync2_reg;
    logic prev_dma_reg, prev_dma_next;
    logic resume_reg, resume_next_v;
    logic jump_reg, jump_next;
    logic irq;
    logic temp_req;

    assign irq = nmi | (maskable_interrupt_inputs & ~interrupt_mask);
    assign temp_req = dma_req | refresh_req | hold_req;

    // two-flop synchroniser on the release pin
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= wait_release_n;
            sync2_reg <= sync1_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        pins_next = pins_reg;
        vec_cnt_next = vec_cnt_reg;
        prev_dma_next = prev_dma_reg;
        resume_next_v = 1'b0;
        jump_next = 1'b0;
        pins_next.ale = 1'b0;
        case (state_reg)
            HSB_RUN: begin
                if (halt_exec) begin
                    state_next = HSB_HALT_CYCLE;
                end else if (wait_exec) begin
                    state_next = HSB_WAITING;
                end else if (cycle_in.valid) begin
                    pins_next.ale = 1'b1;
                    pins_next.bus_cycle_status = cycle_in.status;
                    pins_next.ad_out = cycle_in.data;
                    pins_next.ad_oe = 1'b1;
                    pins_next.upper_address_byte = cycle_in.addr[15:8];
                    pins_next.upper_address_nibble = cycle_in.addr[19:16];
                    pins_next.transceiver_data_enable_n = 1'b0;
                    // direction low only for read-type cycles
                    pins_next.transceiver_direction = !(cycle_in.status == HSB_STATUS_READ_MEM
                        || cycle_in.status == HSB_STATUS_READ_IO || cycle_in.status == HSB_STATUS_FETCH
                        || cycle_in.status == HSB_STATUS_INTA);
                    pins_next.chip_select_block = 1'b0;
                    prev_dma_next = cycle_in.dma_or_refresh;
                end else begin
                    pins_next.bus_cycle_status = HSB_STATUS_IDLE;
                    pins_next.transceiver_data_enable_n = 1'b1;
                    pins_next.transceiver_direction = HSB_TXDIR_RESET;
                end
            end
            HSB_HALT_CYCLE: begin
                pins_next.ale = 1'b1;
                pins_next.bus_cycle_status = HSB_STATUS_HALT;
                pins_next.chip_select_block = 1'b1;
                pins_next.transceiver_data_enable_n = 1'b1;
                pins_next.transceiver_direction = 1'b1;
                case (halt_ad_mode)
                    HSB_AD_WRITE_DATA: begin
                        pins_next.ad_out = last_write_data;
                        pins_next.ad_oe = 1'b1;
                    end
                    HSB_AD_PREFETCH: begin
                        pins_next.ad_out = prefetch_addr[15:0];
                        pins_next.ad_oe = 1'b1;
                    end
                    default: begin
                        pins_next.ad_oe = 1'b0;
                    end
                endcase
                if (bus_8bit) begin
                    pins_next.upper_address_byte = upper_addr_from_prefetch ?
                        prefetch_addr[15:8] : prev_addr[15:8];
                end
                pins_next.upper_address_nibble = prev_dma_reg ? HSB_NIBBLE_DMA : HSB_NIBBLE_ZERO;
                state_next = HSB_HALTED;
            end
            HSB_HALTED: begin
                if (irq) begin
                    state_next = HSB_VECTOR;
                    vec_cnt_next = HSB_VECTOR_READS;
                    pins_next.chip_select_block = 1'b0;
                end else if (temp_req) begin
                    state_next = HSB_TEMP_EXIT;
                end
            end
            HSB_TEMP_EXIT: begin
                if (temp_op_done) begin
                    // return silently: no ale, status stays as left
                    state_next = HSB_HALTED;
                    prev_dma_next = dma_req | refresh_req;
                    // address nibble is not status, so it follows the cycle just run
                    pins_next.upper_address_nibble = (dma_req | refresh_req) ? HSB_NIBBLE_DMA : HSB_NIBBLE_ZERO;
                end
            end
            HSB_VECTOR: begin
                pins_next.ale = 1'b1;
                pins_next.bus_cycle_status = HSB_STATUS_READ_MEM;
                pins_next.ad_oe = 1'b0;
                pins_next.transceiver_data_enable_n = 1'b0;
                pins_next.transceiver_direction = 1'b0;
                prev_dma_next = 1'b0;
                vec_cnt_next = vec_cnt_reg - 2'h1;
                if (vec_cnt_reg == 2'h1) begin
                    state_next = HSB_RUN;
                    jump_next = 1'b1;
                end
            end
            HSB_WAITING: begin
                if (irq) begin
                    state_next = HSB_VECTOR;
                    vec_cnt_next = HSB_VECTOR_READS;
                end else if (!sync2_reg) begin
                    state_next = HSB_RUN;
                    resume_next_v = 1'b1;
                end
            end
            default: begin
                state_next = HSB_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= HSB_RUN;
            pins_reg <= '{ale: 1'b0, bus_cycle_status: HSB_STATUS_IDLE, ad_out: 16'h0000, ad_oe: 1'b0,
                upper_address_byte: 8'h00, upper_address_nibble: HSB_NIBBLE_ZERO, upper_byte_enable: 1'b1,
                transceiver_data_enable_n: 1'b1, transceiver_direction: HSB_TXDIR_RESET,
                chip_select_block: 1'b0};
            vec_cnt_reg <= 2'h0;
            prev_dma_reg <= 1'b0;
            resume_reg <= 1'b0;
            jump_reg <= 1'b0;
            halted <= 1'b0;
            temp_exit <= 1'b0;
            exec_suspended <= 1'b0;
            vector_fetch <= 1'b0;
        end else begin
            state_reg <= state_next;
            pins_reg <= pins_next;
            vec_cnt_reg <= vec_cnt_next;
            prev_dma_reg <= prev_dma_next;
            resume_reg <= resume_next_v;
            jump_reg <= jump_next;
            halted <= (state_next == HSB_HALTED) || (state_next == HSB_TEMP_EXIT);
            temp_exit <= state_next == HSB_TEMP_EXIT;
            exec_suspended <= (state_next != HSB_RUN);
            vector_fetch <= state_next == HSB_VECTOR;
        end
    end

    assign pins = pins_reg;
    assign resume_next = resume_reg;
    assign vector_jump = jump_reg;
endmodule : hsb_halt_bus

// *** sim/hsb_xcvr_model.sv ***
// transceiver and local decode model at the far side of the bus pins
`timescale 1ns/100ps
module hsb_xcvr_model
    import hsb_pkg::*;
(
    input wire hsb_pins_t pins,
    input wire logic local_sel,
    output logic xcvr_oe_n,
    output logic xcvr_a_to_b
);
    // a local-bus access keeps the buffer off so two drivers never meet
    assign xcvr_oe_n = pins.transceiver_data_enable_n | local_sel;
    assign xcvr_a_to_b = pins.transceiver_direction;
endmodule : hsb_xcvr_model

// *** sim/hsb_props.sv ***
// assertions for the halt state bus control block
`timescale 1ns/100ps
module hsb_props
    import hsb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic halt_exec,
    input wire logic wait_exec,
    input wire logic dma_req,
    input wire logic refresh_req,
    input wire logic hold_req,
    input wire logic temp_op_done,
    input wire logic nmi,
    input wire logic maskable_interrupt_inputs,
    input wire logic interrupt_mask,
    input wire logic wait_release_n,
    input wire hsb_pins_t pins,
    input wire logic halted,
    input wire logic temp_exit,
    input wire logic exec_suspended,
    input wire logic vector_fetch,
    input wire logic resume_next,
    input wire logic vector_jump
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire irq = nmi | (maskable_interrupt_inputs & ~interrupt_mask);
    wire treq = dma_req | refresh_req | hold_req;
    halt_entry_a: assert property ($rose(halted) |-> pins.ale && pins.bus_cycle_status == HSB_STATUS_HALT
        && pins.chip_select_block) else $error("halt cycle pins wrong");
    temp_go_a: assert property (halted && !temp_exit && !irq && treq |=> temp_exit) else $error("no temp exit");
    temp_stay_a: assert property (temp_exit && !temp_op_done && !irq |=> temp_exit) else $error("temp exit dropped");
    temp_back_a: assert property (temp_exit && temp_op_done && !irq |=> halted && !temp_exit && !pins.ale
        && pins.bus_cycle_status == HSB_STATUS_HALT) else $error("bad halt return");
    irq_exit_a: assert property (halted && irq && !temp_exit && !vector_fetch |=> vector_fetch) else $error("no exit");
    vec_read_a: assert property ($rose(vector_fetch) |-> ##[0:3] (pins.ale
        && pins.bus_cycle_status == HSB_STATUS_READ_MEM)) else $error("no vector read");
    dir_code_a: assert property (pins.ale |-> pins.transceiver_direction
        == !(pins.bus_cycle_status inside {3'h5, 3'h1, 3'h4, 3'h0})) else $error("direction wrong");
    wait_go_a: assert property (wait_exec && !halt_exec && !exec_suspended && !halted && !vector_fetch
        |=> exec_suspended) else $error("wait not taken");
    resume_a: assert property (resume_next |-> !$past(wait_release_n, 3) && !vector_jump)
        else $error("bad resume");
    cover property ($fell(temp_exit));
    cover property (vector_jump);
    cover property (resume_next);
endmodule : hsb_props
bind hsb_halt_bus hsb_props i_props (.sys_clk, .rstn, .halt_exec, .wait_exec, .dma_req, .refresh_req,
    .hold_req, .temp_op_done, .nmi, .maskable_interrupt_inputs, .interrupt_mask, .wait_release_n, .pins,
    .halted, .temp_exit, .exec_suspended, .vector_fetch, .resume_next, .vector_jump);

// *** sim/tb_top.sv ***
// self-checking bench for the halt state bus control block
`timescale 1ns/100ps
module tb_top;
    import hsb_pkg::*;
    logic sys_clk, rstn, halt_exec, wait_exec, b8, upf, dma, rfs, hld, done, nmi, mint, mask, rel_n, sel;
    logic halted, texit, susp, vf, resume, vjump, oe_n;
    logic [15:0] wdat = 16'h5a3c;
    logic [19:0] pfa = 20'h2468a, pva = 20'h13579;
    hsb_ad_mode_t mode;
    hsb_cycle_t cyc;
    hsb_pins_t pins;
    int n_fail, total_checks, ncyc;
    hsb_halt_bus i_dut (.sys_clk, .rstn, .halt_exec, .wait_exec, .bus_8bit(b8), .halt_ad_mode(mode),
        .last_write_data(wdat), .prefetch_addr(pfa), .prev_addr(pva), .upper_addr_from_prefetch(upf),
        .dma_req(dma), .refresh_req(rfs), .hold_req(hld), .temp_op_done(done), .nmi,
        .maskable_interrupt_inputs(mint), .interrupt_mask(mask), .wait_release_n(rel_n), .cycle_in(cyc),
        .pins, .halted, .temp_exit(texit), .exec_suspended(susp), .vector_fetch(vf), .resume_next(resume),
        .vector_jump(vjump));
    hsb_xcvr_model i_xcvr (.pins, .local_sel(sel), .xcvr_oe_n(oe_n), .xcvr_a_to_b());
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        ncyc++;
        if (ncyc == 5000) begin
            n_fail++;
            results();
        end
    end
    task cy(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cy
    task chk(string nm, logic [19:0] e, logic [19:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task enter_halt(logic [3:0] nib);
        halt_exec = 1;
        cy(1);
        halt_exec = 0;
        cy(1);
        chk("halt", {1'b1, HSB_STATUS_HALT}, {pins.ale, pins.bus_cycle_status});
        chk("cs", 1, pins.chip_select_block);
        chk("den dir", 3, {pins.transceiver_data_enable_n, pins.transceiver_direction});
        chk("nibble", nib, pins.upper_address_nibble);
    endtask : enter_halt
    task leave(bit by_nmi);
        int n;
        n = 0;
        mint = 1;
        mask = 1;
        cy(4);
        chk("masked", 1, halted & !vf);
        nmi = by_nmi;
        mask = by_nmi;
        for (int i = 0; i < 30 && vjump !== 1'b1; i++) begin
            cy(1);
            n += pins.ale && pins.bus_cycle_status == HSB_STATUS_READ_MEM && !pins.transceiver_direction;
        end
        chk("jump", 1, vjump);
        chk("reads", 2, n);
        {nmi, mint, mask} = 0;
        cy(2);
    endtask : leave
    task t_cycles();
        logic [2:0] st [6] = '{3'h5, 3'h1, 3'h4, 3'h0, 3'h6, 3'h2};
        for (int j = 0; j < 6; j++) begin
            cyc = '{1'b1, st[j], 20'h9abcd, 16'h1234, j == 5};
            sel = j[0];
            cy(1);
            chk("ale", 1, pins.ale);
            chk("dir", j > 3, pins.transceiver_direction);
            chk("xcvr off", sel, oe_n);
            cyc.valid = 0;
            cy(1);
        end
        // the last cycle was a dma write, so the halt shows the dma nibble
        enter_halt(8);
        leave(1);
    endtask : t_cycles
    task t_modes();
        for (int m = 0; m < 3; m++) begin
            mode = hsb_ad_mode_t'(m);
            upf = m[0];
            enter_halt(0);
            chk("ad drive", m != 0, pins.ad_oe);
            if (m != 0) chk("ad", m == 1 ? wdat : pfa[15:0], pins.ad_out);
            chk("upper", m[0] ? pfa[15:8] : pva[15:8], pins.upper_address_byte);
            leave(1);
        end
    endtask : t_modes
    task t_temp(int k);
        enter_halt(0);
        {dma, rfs, hld} = 3'b100 >> k;
        cy(5);
        chk("temp", 1, texit);
        done = 1;
        cy(1);
        done = 0;
        {dma, rfs, hld} = 0;
        cy(1);
        chk("back", 2'b10, {halted, texit});
        chk("no ale", {1'b0, HSB_STATUS_HALT}, {pins.ale, pins.bus_cycle_status});
        chk("nib after", k < 2 ? 8 : 0, pins.upper_address_nibble);
        leave(k[0]);
    endtask : t_temp
    task t_wait(bit by_irq);
        wait_exec = 1;
        cy(1);
        wait_exec = 0;
        cy(8);
        chk("suspended", 1, susp);
        nmi = by_irq;
        rel_n = by_irq;
        for (int i = 0; i < 20 && resume !== 1'b1 && vjump !== 1'b1; i++) cy(1);
        chk("wake", {!by_irq, by_irq}, {resume, vjump});
        nmi = 0;
        rel_n = 1;
        cy(3);
        chk("running", 0, susp);
    endtask : t_wait
    task results();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    initial begin
        {rstn, halt_exec, wait_exec, upf, dma, rfs, hld, done, nmi, mint, mask, sel} = 0;
        {rel_n, b8} = 2'h3;
        mode = HSB_AD_FLOAT;
        cyc = 0;
        cy(12);
        rstn = 1;
        t_cycles();
        $display("cycles test done");
        t_modes();
        $display("modes test done");
        for (int k = 0; k < 3; k++) t_temp(k);
        $display("temp test done");
        t_wait(0);
        t_wait(1);
        $display("wait test done");
        results();
    end
endmodule : tb_top
